// >>> hw/mbm_master.sv
// Modbus master for single-bit force and single-word write requests
`default_nettype none
module mbm_master
  import mbm_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire mbm_bus_req_t bus_req,
  output logic [DW-1:0] rd_data_r,
  output logic [7:0] tx_byte_r,
  output logic tx_valid_r,
  input wire logic tx_ready,
  input wire mbm_rx_t rx_in,
  output logic irq_r
);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < NIB_TEN) ? 8'(CHR_DIGIT + {4'h0, n}) : 8'(CHR_ALPHA + {4'h0, n});
  endfunction
  // Letters start at 'A'; the digits '8' and '9' sit above the letter offset
  function automatic logic [3:0] chr_hex(input logic [7:0] c);
    return (c >= 8'(CHR_ALPHA + 8'(NIB_TEN))) ? 4'(c - CHR_ALPHA) : 4'(c - CHR_DIGIT);
  endfunction

  // ==========================================================
  // State
  mbm_state_t state_r, state_nxt;
  logic send_req_r, mode_rtu_r, func_wr_r, force_on_r, act_rtu_r;
  logic [7:0] slave_r, fault_code_r, func_rx_r, code_rx_r;
  logic [15:0] target_r, tmo_r, chk_r, tick_r, ms_r;
  logic [31:0] wval_r;
  logic comm_fault_r, illegal_r, done_r, match_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_en_r;
  logic [5:0] idx_r, rx_cnt_r;
  logic [3:0] nib_r;
  logic [15:0] txb [FRAME_BYTES];
  logic [15:0] rxb [RXB_WORDS];

  // ==========================================================
  // Request image
  wire [15:0] asc_val = {chr_hex(wval_r[7:0]), chr_hex(wval_r[15:8]),
                         chr_hex(wval_r[23:16]), chr_hex(wval_r[31:24])};
  wire [15:0] force_val = force_on_r ? FORCE_ON : FORCE_OFF;
  wire [15:0] wr_val = mode_rtu_r ? wval_r[15:0] : asc_val;
  wire [15:0] data_w = func_wr_r ? wr_val : force_val;
  wire [7:0] func_w = func_wr_r ? FC_WRITE : FC_FORCE;
  logic [7:0] msg_w [MSG_BYTES];
  logic [7:0] fb_w [FRAME_BYTES];
  logic [15:0] crc_w;
  logic [7:0] lrc_w;
  assign msg_w = '{slave_r, func_w, target_r[15:8], target_r[7:0], data_w[15:8], data_w[7:0]};
  always_comb begin
    crc_w = CRC_INIT;
    lrc_w = '0;
    for (int m = 0; m < MSG_BYTES; m++) begin
      crc_w = crc_step(crc_w, msg_w[m]);
      lrc_w = 8'(lrc_w + msg_w[m]);
    end
    lrc_w = 8'(8'h00 - lrc_w);
  end
  // RTU ends in CRC low, high; ASCII ends in the LRC byte
  assign fb_w = '{msg_w[0], msg_w[1], msg_w[2], msg_w[3], msg_w[4], msg_w[5],
                  mode_rtu_r ? crc_w[7:0] : lrc_w, crc_w[15:8]};

  // ==========================================================
  // Decode
  wire [AW-1:0] a = bus_req.addr;
  wire wr_ctrl = bus_req.we && a == A_CTRL;
  wire load_w = state_r == S_IDLE && send_req_r;
  wire tx_fire = tx_valid_r && tx_ready;
  wire [5:0] len = act_rtu_r ? RTU_LEN : ASC_LEN;
  wire [5:0] exc_len = act_rtu_r ? EXC_RTU_LEN : EXC_ASC_LEN;
  // Byte picking stays in plain wires so every change of the image is seen at once
  wire [15:0] tx_word = act_rtu_r ? txb[idx_r[2:0]] : txb[idx_r[3:1]];
  wire [7:0] tx_chr = (!act_rtu_r && idx_r[0]) ? tx_word[15:8] : tx_word[7:0];
  wire [15:0] exp_word = act_rtu_r ? txb[rx_cnt_r[2:0]] : txb[rx_cnt_r[3:1]];
  wire [7:0] exp_chr = (!act_rtu_r && rx_cnt_r[0]) ? exp_word[15:8] : exp_word[7:0];
  wire [7:0] rx_d = rx_in.data;
  wire [5:0] rx_word = act_rtu_r ? rx_cnt_r : {1'b0, rx_cnt_r[5:1]};
  wire rx_room = rx_word < 6'(RXB_WORDS);
  wire rx_take = state_r == S_WAIT && rx_in.valid;
  wire byte_w = rx_take && (act_rtu_r || rx_cnt_r[0]);
  wire [7:0] rx_b = act_rtu_r ? rx_d : {nib_r, chr_hex(rx_d)};
  wire tmo_hit = tmo_r != '0 && ms_r >= tmo_r;
  wire rx_end = state_r == S_WAIT &&
                (rx_in.frame_end || tmo_hit || (rx_take && rx_cnt_r == 6'(len - 6'h01)));
  wire check_w = state_r == S_CHECK;
  // An echo equal to the request also proves the check bytes
  wire ok_w = match_r && rx_cnt_r == len;
  wire exc_w = !ok_w && func_rx_r[EXC_BIT] && chk_r == '0 && rx_cnt_r == exc_len;
  wire start_w = state_r != S_SEND && state_nxt == S_SEND;
  wire [IRQ_W-1:0] evt_w = {check_w && exc_w, check_w && !ok_w && !exc_w, check_w && ok_w};

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (send_req_r) state_nxt = S_SEND;
      end
      S_SEND: begin
        if (tx_fire && idx_r == 6'(len - 6'h01)) state_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (rx_end) state_nxt = S_CHECK;
      end
      S_CHECK: begin
        state_nxt = (!ok_w && send_req_r) ? S_SEND : S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      idx_r <= '0;
      act_rtu_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_w) idx_r <= '0;
      else if (tx_fire) idx_r <= idx_r + 6'h01;
      if (load_w) act_rtu_r <= mode_rtu_r;
    end
  end

  // A bubble after each byte keeps the handshake simple; the line is far slower
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_valid_r <= 1'b0;
      tx_byte_r <= '0;
    end else if (state_r == S_SEND && !tx_valid_r) begin
      tx_valid_r <= 1'b1;
      tx_byte_r <= tx_chr;
    end else if (tx_fire) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Transmit image is frozen at start so a retry repeats it exactly
  for (genvar i = 0; i < FRAME_BYTES; i++) begin : g_txb
    wire [15:0] img = mode_rtu_r ? {8'h00, fb_w[i]} :
                      (i < ASC_WORDS) ? {hex_chr(fb_w[i][3:0]), hex_chr(fb_w[i][7:4])} : 16'h0000;
    always_ff @(posedge ref_clk) begin
      if (!rst_n) txb[i] <= '0;
      else if (load_w) txb[i] <= img;
    end
  end

  for (genvar j = 0; j < RXB_WORDS; j++) begin : g_rxb
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        rxb[j] <= '0;
      end else if (rx_take && rx_room && rx_word == 6'(j)) begin
        // Raw characters only; no conversion of the echo
        if (!act_rtu_r && rx_cnt_r[0]) rxb[j] <= {rx_d, rxb[j][7:0]};
        else rxb[j] <= {8'h00, rx_d};
      end
    end
  end

  // ==========================================================
  // Receive checking
  always_ff @(posedge ref_clk) begin
    if (!rst_n || start_w) begin
      rx_cnt_r <= '0;
      match_r <= 1'b1;
      nib_r <= '0;
      chk_r <= (rst_n && (load_w ? mode_rtu_r : act_rtu_r)) ? CRC_INIT : '0;
      func_rx_r <= '0;
      code_rx_r <= '0;
    end else if (rx_take) begin
      if (rx_room) rx_cnt_r <= rx_cnt_r + 6'h01;
      match_r <= match_r && rx_room && rx_cnt_r < len && rx_d == exp_chr;
      if (!act_rtu_r && !rx_cnt_r[0]) nib_r <= chr_hex(rx_d);
      if (byte_w) begin
        chk_r <= act_rtu_r ? crc_step(chk_r, rx_b) : {8'h00, 8'(chk_r[7:0] + rx_b)};
        if (rx_word == BYTE_FUNC) func_rx_r <= rx_b;
        if (rx_word == BYTE_CODE) code_rx_r <= rx_b;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_r != S_WAIT) begin
      tick_r <= '0;
      ms_r <= '0;
    end else if (tick_r == 16'(TICK_CYC_P - 1)) begin
      tick_r <= '0;
      ms_r <= ms_r + 16'h0001;
    end else begin
      tick_r <= tick_r + 16'h0001;
    end
  end

  // ==========================================================
  // Registers and flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {send_req_r, mode_rtu_r, func_wr_r, force_on_r} <= '0;
      slave_r <= '0;
      target_r <= '0;
      wval_r <= '0;
      tmo_r <= '0;
      irq_en_r <= '0;
    end else begin
      if (wr_ctrl) begin
        send_req_r <= bus_req.wdata[CTRL_SEND];
        mode_rtu_r <= bus_req.wdata[CTRL_MODE];
        func_wr_r <= bus_req.wdata[CTRL_FUNC];
        force_on_r <= bus_req.wdata[CTRL_FORCE];
      end else if (check_w && ok_w) begin
        send_req_r <= 1'b0;
      end
      if (bus_req.we && a == A_SLAVE) slave_r <= bus_req.wdata[7:0];
      if (bus_req.we && a == A_TARGET) target_r <= bus_req.wdata[15:0];
      if (bus_req.we && a == A_WVAL) wval_r <= bus_req.wdata;
      if (bus_req.we && a == A_TMO) tmo_r <= bus_req.wdata[15:0];
      if (bus_req.we && a == A_IRQ_EN) irq_en_r <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      comm_fault_r <= 1'b0;
      illegal_r <= 1'b0;
      done_r <= 1'b0;
      fault_code_r <= '0;
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (evt_w[IRQ_FAULT]) comm_fault_r <= 1'b1;
      else if (evt_w[IRQ_OK]) comm_fault_r <= 1'b0;
      if (evt_w[IRQ_ILLEGAL]) illegal_r <= 1'b1;
      else if (evt_w[IRQ_OK]) illegal_r <= 1'b0;
      if (evt_w[IRQ_ILLEGAL]) fault_code_r <= code_rx_r;
      if (check_w) done_r <= 1'b1;
      else if (load_w) done_r <= 1'b0;
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~((bus_req.we && a == A_IRQ_CLR) ? bus_req.wdata[IRQ_W-1:0] : '0)) | evt_w;
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // ==========================================================
  // Read port
  logic [DW-1:0] ctrl_rd, stat_rd;
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[CTRL_SEND] = send_req_r;
    ctrl_rd[CTRL_MODE] = mode_rtu_r;
    ctrl_rd[CTRL_FUNC] = func_wr_r;
    ctrl_rd[CTRL_FORCE] = force_on_r;
    stat_rd = '0;
    stat_rd[ST_FAULT] = comm_fault_r;
    stat_rd[ST_ILLEGAL] = illegal_r;
    stat_rd[ST_DONE] = done_r;
    stat_rd[ST_BUSY] = state_r != S_IDLE;
  end
  wire [AW-1:0] tx_off = AW'(a - A_TXB);
  wire in_tx = a >= A_TXB && a < A_TXB_END;
  wire in_rx = a >= A_RXB && a < A_RXB_END;
  wire [DW-1:0] rd_mux =
    (a == A_CTRL) ? ctrl_rd :
    (a == A_SLAVE) ? {24'h0, slave_r} :
    (a == A_TARGET) ? {16'h0, target_r} :
    (a == A_WVAL) ? wval_r :
    (a == A_STATUS) ? stat_rd :
    (a == A_FCODE) ? {24'h0, fault_code_r} :
    (a == A_TMO) ? {16'h0, tmo_r} :
    (a == A_IRQ_ST) ? {29'h0, irq_stat_r} :
    (a == A_IRQ_EN) ? {29'h0, irq_en_r} :
    (in_tx && tx_off < AW'(FRAME_BYTES)) ? {16'h0, txb[tx_off[2:0]]} :
    in_rx ? {16'h0, rxb[a[3:0]]} : '0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) rd_data_r <= '0;
    else rd_data_r <= bus_req.re ? rd_mux : '0;
  end

  // ==========================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rtu_len_a: assert property (
    (state_r == S_SEND && act_rtu_r && tx_fire && idx_r == 6'h07) |=> state_r == S_WAIT)
    else $error("RTU request not eight bytes");
  asc_len_a: assert property (
    (state_r == S_SEND && !act_rtu_r && tx_fire && idx_r < 6'h0d) |=> state_r == S_SEND)
    else $error("ASCII request ended before fourteen characters");
  force_data_a: assert property (
    (load_w && mode_rtu_r && !func_wr_r) |=>
      txb[1][7:0] == FC_FORCE && {txb[4][7:0], txb[5][7:0]} == ($past(force_on_r) ? FORCE_ON : FORCE_OFF))
    else $error("Force request data wrong");
  write_data_a: assert property (
    (load_w && mode_rtu_r && func_wr_r) |=> txb[1][7:0] == FC_WRITE && {txb[4][7:0], txb[5][7:0]} == $past(wval_r[15:0]))
    else $error("Write request data wrong");
  tx_hold_a: assert property (
    (tx_valid_r && !tx_ready) |=> tx_valid_r && $stable(tx_byte_r))
    else $error("Transmit byte dropped before accept");
  fault_set_a: assert property (
    (check_w && !ok_w && !exc_w) |=> comm_fault_r && done_r)
    else $error("Faulty reply not flagged");
  illegal_set_a: assert property (
    (check_w && exc_w) |=> illegal_r && fault_code_r == $past(code_rx_r))
    else $error("Exception reply not flagged");
  retry_send_a: assert property (
    (check_w && !ok_w && send_req_r && !wr_ctrl) |=> state_r == S_SEND ##1 tx_valid_r && tx_byte_r == txb[0][7:0])
    else $error("Faulty reply not retried");
  ok_clear_a: assert property (
    (check_w && ok_w) |=> !comm_fault_r && !illegal_r && state_r == S_IDLE)
    else $error("Good reply did not clear faults");
  rx_store_a: assert property (
    (rx_take && rx_cnt_r == 6'h00) |=> rxb[0][7:0] == $past(rx_d))
    else $error("First reply byte not stored raw");
  tmo_fault_a: assert property (
    (state_r == S_WAIT && tmo_hit && !rx_in.valid) |=> check_w && !ok_w)
    else $error("Receive timeout not treated as fault");
  done_flag_a: assert property (
    check_w |=> done_r)
    else $error("Receive complete not flagged");
  irq_level_a: assert property (
    (|(irq_stat_r & irq_en_r)) |=> irq_r)
    else $error("Enabled event did not raise interrupt");

  ok_path_c: cover property (check_w && ok_w ##1 state_r == S_IDLE);
  exc_path_c: cover property (check_w && exc_w);
  retry_c: cover property (check_w && !ok_w ##[1:400] check_w && ok_w);
  timeout_c: cover property (state_r == S_WAIT && tmo_hit);
  ascii_ok_c: cover property (check_w && ok_w && !act_rtu_r);
endmodule // mbm_master
`default_nettype wire

// >>> hw/mbm_pkg.sv
// Constants and carrier types of the Modbus single-write master
// Overview of operation
// - Mode bit off frames ASCII, mode bit on frames RTU.
// - Force on sends data FF00, force off sends data 0000.
// - Request leaves from transmit buffer; reply is stored in receive buffer.
// - RTU value is hex, reply fills eight words; ASCII value is characters, seven.
// - Every reply is checked; a faulty one sets the communication fault flag.
// - An exception reply stores its code and sets the illegal address flag.
// - After either fault the same request is resent; a good reply clears both.
// - ASCII: two hex characters per byte, low byte first, ending in LRC.
// - RTU: one byte per word low byte, address first, CRC low then high.
// - Function 05 forces one remote bit on or off.
// - Function 06 writes one remote data word.
// - The echoed reply is only stored and checked, never converted.
`default_nettype none
package mbm_pkg;
  // ==========================================================
  // Sizes
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int MSG_BYTES = 6;
  localparam int FRAME_BYTES = 8;
  localparam int RXB_WORDS = 16;
  localparam logic [5:0] RTU_LEN = 6'h08;
  localparam logic [5:0] ASC_LEN = 6'h0e;
  localparam logic [5:0] EXC_RTU_LEN = 6'h05;
  localparam logic [5:0] EXC_ASC_LEN = 6'h08;
  localparam logic [5:0] BYTE_FUNC = 6'h01;
  localparam logic [5:0] BYTE_CODE = 6'h02;
  localparam int ASC_WORDS = 7;
  localparam int EXC_BIT = 7;
  // ==========================================================
  // Protocol values
  localparam logic [7:0] FC_FORCE = 8'h05;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [15:0] FORCE_ON = 16'hff00;
  localparam logic [15:0] FORCE_OFF = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] CHR_DIGIT = 8'h30;
  localparam logic [7:0] CHR_ALPHA = 8'h37;
  localparam logic [3:0] NIB_TEN = 4'ha;
  // ==========================================================
  // Register map (word addresses) and fields
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_SLAVE = 8'h01;
  localparam logic [AW-1:0] A_TARGET = 8'h02;
  localparam logic [AW-1:0] A_WVAL = 8'h03;
  localparam logic [AW-1:0] A_STATUS = 8'h04;
  localparam logic [AW-1:0] A_FCODE = 8'h05;
  localparam logic [AW-1:0] A_TMO = 8'h06;
  localparam logic [AW-1:0] A_IRQ_ST = 8'h08;
  localparam logic [AW-1:0] A_IRQ_CLR = 8'h09;
  localparam logic [AW-1:0] A_IRQ_EN = 8'h0a;
  localparam logic [AW-1:0] A_TXB = 8'h40;
  localparam logic [AW-1:0] A_TXB_END = 8'h68;
  localparam logic [AW-1:0] A_RXB = 8'h80;
  localparam logic [AW-1:0] A_RXB_END = 8'h90;
  localparam int CTRL_SEND = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_FUNC = 2;
  localparam int CTRL_FORCE = 3;
  localparam int ST_FAULT = 0;
  localparam int ST_ILLEGAL = 1;
  localparam int ST_DONE = 2;
  localparam int ST_BUSY = 3;
  localparam int IRQ_W = 3;
  localparam int IRQ_OK = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_ILLEGAL = 2;
  // ==========================================================
  // Timing: receive timeout counts in milliseconds
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Types
  typedef struct packed {
    logic we;
    logic re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } mbm_bus_req_t;
  typedef struct packed {
    logic valid;
    logic frame_end;
    logic [7:0] data;
  } mbm_rx_t;
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT, S_CHECK} mbm_state_t;
endpackage
`default_nettype wire

// >>> tb/mbm_remote.sv
// Behavioural remote station: echoes each request, or answers with a bad or an exception reply, or stays silent
`default_nettype none
module mbm_remote
  import mbm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [1:0] reply_mode,
  input wire logic [5:0] frame_len,
  input wire logic [7:0] tx_byte_r,
  input wire logic tx_valid_r,
  output logic tx_ready,
  output mbm_rx_t rx_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [0:15];
  logic [7:0] rp [0:15];
  logic [15:0] c;
  int n, lim, p;
  // ==========================================================
  // Check value
  function automatic logic [15:0] crc16(input logic [7:0] b [0:15], input int cnt);
    logic [15:0] r;
    r = CRC_INIT;
    for (int i = 0; i < cnt; i++) begin
      r ^= {8'h00, b[i]};
      for (int j = 0; j < 8; j++) r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
    end
    return r;
  endfunction
  // ==========================================================
  // Capture a request, then answer it
  initial begin
    tx_ready = 1'b0;
    rx_in = '{valid: 1'b0, frame_end: 1'b0, data: 8'h00};
    p = 0;
    forever begin
      n = 0;
      while (n < int'(frame_len)) begin
        @(posedge ref_clk);
        if (tx_valid_r && tx_ready) begin
          got[n] = tx_byte_r;
          n++;
        end
        p++;
        // Stalls now and then so the sender has to hold its byte; low once the frame is in
        tx_ready <= (p % 5) != 0 && n < int'(frame_len);
      end
      rp = got;
      lim = int'(frame_len);
      if (reply_mode == 2'h2) begin
        rp[1] = rp[1] | 8'h80;
        rp[2] = 8'h02;
        c = crc16(rp, 3);
        {rp[4], rp[3]} = c;
        lim = 5;
      end
      if (reply_mode == 2'h1) rp[lim-1] = ~rp[lim-1];
      // A silent station leaves the master to its receive timeout
      if (reply_mode == 2'h3) lim = 0;
      repeat (6) @(posedge ref_clk);
      for (int k = 0; k < lim; k++) begin
        rx_in <= '{valid: 1'b1, frame_end: 1'b0, data: rp[k]};
        @(posedge ref_clk);
        // The line does not keep showing the last byte
        rx_in <= '{valid: 1'b0, frame_end: 1'b0, data: ~rp[k]};
        @(posedge ref_clk);
      end
      if (lim > 0) begin
        rx_in <= '{valid: 1'b0, frame_end: 1'b1, data: 8'h00};
        @(posedge ref_clk);
        rx_in <= '{valid: 1'b0, frame_end: 1'b0, data: 8'hff};
      end
    end
  end
endmodule // mbm_remote
`default_nettype wire

// >>> tb/modbus_master_single_write_tb.sv
// Self-checking bench of the Modbus single-write master
`default_nettype none
module modbus_master_single_write_tb
  import mbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, tx_ready, tx_valid_r, irq_r;
  mbm_bus_req_t bus_req;
  mbm_rx_t rx_in;
  logic [DW-1:0] rd_data_r;
  logic [7:0] tx_byte_r;
  logic [1:0] reply_mode;
  logic [5:0] frame_len;
  logic [31:0] seed, st;
  logic [7:0] m [0:15];
  logic [7:0] e [0:15];
  int err_count, tests_run;

  mbm_master #(.TICK_CYC_P(10)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data_r(rd_data_r),
    .tx_byte_r(tx_byte_r), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .rx_in(rx_in), .irq_r(irq_r));
  mbm_remote prt (.ref_clk(ref_clk), .reply_mode(reply_mode), .frame_len(frame_len), .tx_byte_r(tx_byte_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .rx_in(rx_in));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] d);
    return (d < NIB_TEN) ? CHR_DIGIT + {4'h0, d} : CHR_ALPHA + {4'h0, d};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 d = rd_data_r;
  endtask
  task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask
  task automatic wait_st(input logic [3:0] mask, input logic [3:0] want);
    int i;
    i = 0;
    st = 32'h0;
    while ((st[3:0] & mask) !== want && i < 3000) begin
      rd(A_STATUS, st);
      i++;
    end
    chk("status", {28'h0, st[3:0] & mask}, {28'h0, want});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // One transaction: build the expected frame, start it, judge it
  task automatic xfer(input logic rtu, input logic fw, input logic fon, input logic [7:0] sl,
      input logic [15:0] tgt, input logic [15:0] v, input logic [1:0] rm);
    logic [7:0] sum;
    int n;
    m[0] = sl;
    m[1] = fw ? FC_WRITE : FC_FORCE;
    {m[2], m[3]} = tgt;
    {m[4], m[5]} = fw ? v : (fon ? FORCE_ON : FORCE_OFF);
    sum = 8'h00;
    for (int i = 0; i < 6; i++) sum += m[i];
    {m[7], m[6]} = prt.crc16(m, 6);
    if (!rtu) m[6] = -sum;
    for (int i = 0; i < 8; i++) begin
      e[2*i] = hx(m[i][7:4]);
      e[2*i+1] = hx(m[i][3:0]);
    end
    n = rtu ? 8 : 14;
    wr(A_SLAVE, {24'h0, sl});
    frame_len <= n[5:0];
    reply_mode <= rm;
    wr(A_TARGET, {16'h0, tgt});
    wr(A_WVAL, rtu ? {16'h0, v} : {hx(v[3:0]), hx(v[7:4]), hx(v[11:8]), hx(v[15:12])});
    wr(A_CTRL, {28'h0, fon, fw, rtu, 1'b1});
    repeat (4) @(posedge ref_clk);
    if (rm == 2'h1 || rm == 2'h3) begin
      wait_st(4'h1, 4'h1);
      reply_mode <= 2'h0;
    end
    if (rm == 2'h2) begin
      wait_st(4'h2, 4'h2);
      chkrd("fault code", A_FCODE, 32'h2);
      reply_mode <= 2'h0;
    end
    wait_st(4'hf, 4'h4);
    for (int i = 0; i < n; i++) chk("sent", {24'h0, prt.got[i]}, {24'h0, rtu ? m[i] : e[i]});
    chkrd("tx word", A_TXB, rtu ? {24'h0, m[0]} : {16'h0, e[1], e[0]});
    for (int k = 0; k < (rtu ? 8 : ASC_WORDS); k++)
      chkrd("rx word", A_RXB + k[7:0], rtu ? {24'h0, m[k]} : {16'h0, e[2*k+1], e[2*k]});
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    stop_test;
  end
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    frame_len = 6'h3f;
    reply_mode = 2'h0;
    seed = 32'hadfafca5;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    chkrd("status", A_STATUS, 32'h0);
    chkrd("unmapped", 8'h07, 32'h0);
    wr(A_IRQ_EN, 32'h7);
    xfer(1'b1, 1'b0, 1'b1, 8'h01, 16'h0500, 16'h0000, 2'h0);
    chk("crc", {16'h0, prt.got[7], prt.got[6]}, 32'hf68c);
    chk("irq", 32'(irq_r), 32'h1);
    wr(A_IRQ_CLR, 32'h1);
    wr(A_IRQ_EN, 32'h0);
    xfer(1'b1, 1'b1, 1'b0, 8'h01, 16'h0706, 16'h1770, 2'h0);
    chk("crc", {16'h0, prt.got[7], prt.got[6]}, 32'hab66);
    chk("irq masked", 32'(irq_r), 32'h0);
    chkrd("irq status", A_IRQ_ST, 32'h1);
    chkrd("irq clear", A_IRQ_CLR, 32'h0);
    wr(A_IRQ_CLR, 32'h7);
    wr(A_IRQ_EN, 32'h6);
    xfer(1'b0, 1'b0, 1'b0, 8'h01, 16'h0500, 16'h0000, 2'h1);
    chkrd("irq status", A_IRQ_ST, 32'h3);
    chk("irq fault", 32'(irq_r), 32'h1);
    xfer(1'b1, 1'b1, 1'b0, 8'h11, 16'h8000, 16'h1234, 2'h2);
    chkrd("irq status", A_IRQ_ST, 32'h7);
    wr(A_TMO, 32'h5);
    chkrd("timeout", A_TMO, 32'h5);
    xfer(1'b0, 1'b1, 1'b0, 8'h01, 16'h0706, 16'h1770, 2'h3);
    chk("lrc", {16'h0, prt.got[12], prt.got[13]}, 32'h3635);
    for (int r = 0; r < 6; r++) begin
      seed = lfsr(seed);
      xfer(seed[0], seed[1], seed[2], seed[15:8], seed[31:16], seed[27:12], {1'b0, seed[3] & seed[4]});
    end
    stop_test;
  end
endmodule // modbus_master_single_write_tb
`default_nettype wire
